// ---- rtl/nibble_swap_table_read_exec.sv ----
// Operation
// - Nibble exchange swaps source byte halves; decoded from 0001 110d ffff ffff.
// - Nibble exchange dest bit 0 writes working register, 1 writes file register.
// - Table read copies latch high byte if select 1, else low byte, to file.
// - Then the whole program word at the pointer reloads the 16-bit latch.
// - Sixteen-bit lookup pointer addresses program memory for the table read fetch.
// - Increment bit 1 bumps pointer after access; 0 leaves it unchanged.
// - Table read lasts two cycles, three when destination is program counter low.
`timescale 1ns/1ns
`default_nettype none
module nibble_swap_table_read_exec
  import nibble_table_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic                            insn_valid,
  input  wire logic [nibble_table_pkg::INSN_W-1:0] insn,
  input  wire logic [nibble_table_pkg::DATA_W-1:0] file_rdata,
  input  wire logic [nibble_table_pkg::INSN_W-1:0] pmem_rdata,
  output var  logic                            busy,
  output var  logic                            working_register_we,
  output var  logic [nibble_table_pkg::DATA_W-1:0] working_register,
  output var  logic                            file_we,
  output var  logic [nibble_table_pkg::FADDR_W-1:0] file_waddr,
  output var  logic [nibble_table_pkg::DATA_W-1:0] file_wdata,
  output var  logic [nibble_table_pkg::PTR_W-1:0]  pmem_addr,
  output var  logic                            pmem_oe_n,
  output var  logic [nibble_table_pkg::INSN_W-1:0] lookup_word_latch,
  output var  logic [nibble_table_pkg::PTR_W-1:0]  lookup_pointer
);
  import nibble_table_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_FLUSH = 3'b100
  } exec_state_e;

  exec_state_e        state_r;
  logic               inc_r;
  logic               to_pc_low_r;
  logic               busy_r;
  logic               working_we_r;
  logic [DATA_W-1:0]  working_r;
  logic               file_we_r;
  logic [FADDR_W-1:0] file_waddr_r;
  logic [DATA_W-1:0]  file_wdata_r;
  logic [PTR_W-1:0]   pmem_addr_r;
  logic               pmem_oe_n_r;
  logic [INSN_W-1:0]  latch_r;
  logic [PTR_W-1:0]   pointer_r;
  logic               idle;
  logic               is_swap;
  logic               is_trd;
  logic [DATA_W-1:0]  swapped;
  logic [DATA_W-1:0]  latch_sel;

  // ==========================================================
  // Helpers
  // Exchanges the upper and lower halves of a byte
  function automatic logic [DATA_W-1:0] swap_nib(input logic [DATA_W-1:0] v);
    swap_nib = {v[DATA_W/2-1:0], v[DATA_W-1:DATA_W/2]};
  endfunction

  function automatic logic is_swap_word(input logic [INSN_W-1:0] w);
    is_swap_word = (w[INSN_W-1:SWAP_OPC_LSB] == SWAP_OPC);
  endfunction

  function automatic logic is_trd_word(input logic [INSN_W-1:0] w);
    is_trd_word = (w[INSN_W-1:TRD_OPC_LSB] == TRD_OPC);
  endfunction

  function automatic logic hits_pc_low(input logic [INSN_W-1:0] w);
    hits_pc_low = (w[FADDR_W-1:0] == PROG_CNT_LOW_ADDR);
  endfunction

  function automatic logic [DATA_W-1:0] pick_byte(input logic [INSN_W-1:0] word,
                                                  input logic              high);
    if (high) begin
      pick_byte = word[INSN_W-1:DATA_W];
    end else begin
      pick_byte = word[DATA_W-1:0];
    end
  endfunction

  // ==========================================================
  // Decode
  // Words offered while a table read is in flight are dropped
  assign idle      = (state_r == ST_IDLE);
  assign is_swap   = insn_valid && idle && is_swap_word(insn);
  assign is_trd    = insn_valid && idle && is_trd_word(insn);
  assign swapped   = swap_nib(file_rdata);
  assign latch_sel = pick_byte(latch_r, insn[TRD_HIGH_BIT]);

  // ==========================================================
  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      inc_r       <= 1'b0;
      to_pc_low_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (is_trd) begin
            state_r     <= ST_FETCH;
            inc_r       <= insn[TRD_INC_BIT];
            to_pc_low_r <= hits_pc_low(insn);
          end
        end
        ST_FETCH: begin
          // A write to the program counter low byte costs one flush cycle
          if (to_pc_low_r) begin
            state_r <= ST_FLUSH;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_FLUSH: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Busy covers every cycle after the decode cycle of a table read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (is_trd) begin
      busy_r <= 1'b1;
    end else if (state_r == ST_FETCH) begin
      busy_r <= to_pc_low_r;
    end else begin
      busy_r <= 1'b0;
    end
  end

  // ==========================================================
  // Working register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      working_we_r <= 1'b0;
    end else begin
      working_we_r <= is_swap && !insn[SWAP_DEST_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      working_r <= '0;
    end else if (is_swap && !insn[SWAP_DEST_BIT]) begin
      working_r <= swapped;
    end
  end

  // ==========================================================
  // File register write
  // A table read writes the latch byte held before its own reload
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      file_we_r <= 1'b0;
    end else begin
      file_we_r <= (is_swap && insn[SWAP_DEST_BIT]) || is_trd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      file_waddr_r <= '0;
    end else if (is_swap || is_trd) begin
      file_waddr_r <= insn[FADDR_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      file_wdata_r <= '0;
    end else if (is_swap && insn[SWAP_DEST_BIT]) begin
      file_wdata_r <= swapped;
    end else if (is_trd) begin
      file_wdata_r <= latch_sel;
    end
  end

  // ==========================================================
  // Program memory fetch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pmem_oe_n_r <= 1'b1;
    end else begin
      pmem_oe_n_r <= !is_trd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pmem_addr_r <= '0;
    end else if (is_trd) begin
      pmem_addr_r <= pointer_r;
    end
  end

  // Latch takes the word at the end of the strobe cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latch_r <= LATCH_RST;
    end else if (state_r == ST_FETCH) begin
      latch_r <= pmem_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pointer_r <= PTR_RST;
    end else if (state_r == ST_FETCH && inc_r) begin
      pointer_r <= pointer_r + PTR_STEP;
    end
  end

  // ==========================================================
  // Outputs
  assign busy                = busy_r;
  assign working_register_we = working_we_r;
  assign working_register    = working_r;
  assign file_we             = file_we_r;
  assign file_waddr          = file_waddr_r;
  assign file_wdata          = file_wdata_r;
  assign pmem_addr           = pmem_addr_r;
  assign pmem_oe_n           = pmem_oe_n_r;
  assign lookup_word_latch   = latch_r;
  assign lookup_pointer      = pointer_r;
endmodule
`default_nettype wire

// ---- rtl/nibble_table_pkg.sv ----
package nibble_table_pkg;
  localparam int          INSN_W          = 16;
  localparam int          DATA_W          = 8;
  localparam int          PTR_W           = 16;
  localparam int          FADDR_W         = 8;
  // Opcode patterns, compared on the bits above the operand fields
  localparam logic [6:0]  SWAP_OPC        = 7'h0e;  // 0001 110d
  localparam int          SWAP_OPC_LSB    = 9;
  localparam int          SWAP_DEST_BIT   = 8;
  localparam logic [5:0]  TRD_OPC         = 6'h2a;  // 1010 10ti
  localparam int          TRD_OPC_LSB     = 10;
  localparam int          TRD_HIGH_BIT    = 9;
  localparam int          TRD_INC_BIT     = 8;
  localparam logic [7:0]  PROG_CNT_LOW_ADDR = 8'h02;
  localparam logic [15:0] LATCH_RST       = 16'h0000;
  localparam logic [15:0] PTR_RST         = 16'h0000;
  localparam logic [15:0] PTR_STEP        = 16'h0001;
endpackage

// ---- tb/pmem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmem_model (
  input  wire logic        sys_clk,
  input  wire logic        pmem_oe_n,
  input  wire logic [15:0] pmem_addr,
  output var  logic [15:0] pmem_rdata
);
  logic [15:0] last_r = '0;
  always_ff @(posedge sys_clk) if (!pmem_oe_n) last_r <= pmem_rdata;
  // Released bus shows the inverse of the last word
  assign pmem_rdata = pmem_oe_n ? ~last_r : pmem_addr ^ 16'h5aa5;
endmodule
`default_nettype wire

// ---- tb/nibble_exec_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module nibble_exec_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        insn_valid,
  input wire logic        busy,
  input wire logic        file_we,
  input wire logic        working_register_we,
  input wire logic        pmem_oe_n,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic [15:0] insn,
  input wire logic [15:0] pmem_rdata,
  input wire logic [15:0] pmem_addr,
  input wire logic [15:0] lookup_word_latch,
  input wire logic [15:0] lookup_pointer
);
  wire sw = insn_valid && !busy && insn[15:9] == 7'h0e;
  wire tr = insn_valid && !busy && insn[15:10] == 6'h2a;
  wire [7:0] sx = {file_rdata[3:0], file_rdata[7:4]};
  wire [7:0] lb = insn[9] ? lookup_word_latch[15:8] : lookup_word_latch[7:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_sw; sw && insn[8] |=> file_we && file_wdata == $past(sx); endproperty
  a_sw: assert property (p_sw) else $error("swap data");
  property p_wd; sw && !insn[8] |=> working_register_we && !file_we; endproperty
  a_wd: assert property (p_wd) else $error("swap dest");
  property p_rb; tr |=> file_we && file_wdata == $past(lb); endproperty
  a_rb: assert property (p_rb) else $error("latch byte");
  property p_ld; tr |=> ##1 lookup_word_latch == $past(pmem_rdata); endproperty
  a_ld: assert property (p_ld) else $error("latch load");
  property p_ad; tr |=> pmem_addr == $past(lookup_pointer); endproperty
  a_ad: assert property (p_ad) else $error("fetch addr");
  property p_in; tr |=> ##1 lookup_pointer == $past(lookup_pointer, 2) + $past(insn[8], 2); endproperty
  a_in: assert property (p_in) else $error("pointer");
  property p_cy; tr |=> busy ##1 busy == $past(insn[7:0] == 8'h02, 2); endproperty
  a_cy: assert property (p_cy) else $error("cycles");
  property p_oe; tr |=> !pmem_oe_n ##1 pmem_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("strobe");
  c_sw: cover property (sw); c_rd: cover property (tr && insn[8]);
  c_pc: cover property (tr && insn[7:0] == 8'h02);
endmodule
bind nibble_swap_table_read_exec nibble_exec_asserts nibble_exec_asserts_i (.*);
`default_nettype wire

// ---- tb/tb_nibble_swap_table_read_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_nibble_swap_table_read_exec;
  logic sys_clk = 0, rst_n = 0, insn_valid = 0, busy, working_register_we, file_we, pmem_oe_n;
  logic [7:0] file_rdata = '0, working_register, file_waddr, file_wdata;
  logic [15:0] insn = '0, pmem_rdata, pmem_addr, lookup_word_latch, lookup_pointer;
  logic [15:0] pe = '0, le = '0;
  logic [3:0] ctl;
  assign ctl = {busy, working_register_we, file_we, pmem_oe_n};
  int miscompares = 0, total_checks = 0, cyc = 0;
  nibble_swap_table_read_exec nibble_swap_table_read_exec_i (.*);
  pmem_model pmem_model_i (.*);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc > 400) begin miscompares++; test_done; end
  task test_done; if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish; endtask
  task chk(input string n, input logic [15:0] e, g); total_checks++;
    if (g !== e) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
  endtask
  task issue(input logic [15:0] op, input logic [7:0] fd);
    @(negedge sys_clk);
    insn_valid = 1'b1;
    insn       = op;
    file_rdata = fd;
    @(negedge sys_clk);
    insn_valid = 1'b0;
  endtask
  task t_swap;
    issue(16'h1c53, 8'h53);
    chk("working_register", 16'h8035, {working_register_we, file_we, 6'h00, working_register});
    issue(16'h1dc7, 8'hc6);
    chk("file", 16'h40c7, {working_register_we, file_we, 6'h00, file_waddr});
    chk("fdata", 16'h356c, {working_register, file_wdata});
    issue(16'h1e53, 8'h53);
    chk("refused", 16'h0001, {12'h000, ctl});
  endtask
  task t_rd(input logic [1:0] ti, input logic [7:0] f);
    logic [7:0] b;
    b = ti[1] ? le[15:8] : le[7:0];
    issue({6'h2a, ti, f}, 8'h00);
    chk("rd_ctl", 16'h000a, {12'h000, ctl});
    chk("rd_file", {b, f}, {file_wdata, file_waddr});
    chk("addr", pe, pmem_addr);
    le = pe ^ 16'h5aa5;
    pe = pe + {15'h0000, ti[0]};
    @(negedge sys_clk);
    chk("latch", le, lookup_word_latch);
    chk("ptr", pe, lookup_pointer);
    chk("rd_ext", {12'h000, f == 8'h02, 3'h1}, {12'h000, ctl});
    @(negedge sys_clk);
    chk("rd_end", 16'h0001, {12'h000, ctl});
  endtask
  initial begin repeat (6) @(negedge sys_clk); rst_n = 1; t_swap;
    t_rd(2'h3, 8'h10); t_rd(2'h0, 8'h11); t_rd(2'h2, 8'h02); t_rd(2'h1, 8'h02);
    test_done; end
endmodule
`default_nettype wire
